/* core/prs_sequencer.v */
// power resource sequencer: resource state machine and power control gating
`timescale 1ns/1ns
`include "prs_defines.vh"
module prs_sequencer #(
  parameter NRES = `PRS_NRES,
  parameter NCLK = `PRS_NCLK,
  parameter TW = `PRS_TW
) (
  input wire MCLK,
  input wire RST,
  input wire LOW_POWER_OSC_CLOCK,
  input wire WLAN_POWER_CTRL_IN,
  input wire BT_POWER_CTRL_IN,
  input wire SHUTDOWN,
  input wire [NCLK-1:0] CLK_REQ,
  input wire [NCLK*NRES-1:0] CLK_MAP,
  input wire [NRES-1:0] MIN_RESOURCE_MASK,
  input wire [NRES-1:0] TIMER_REQ,
  input wire [NRES*NRES-1:0] DEP_TABLE,
  input wire [NRES*TW-1:0] ON_DELAY,
  input wire [NRES*TW-1:0] OFF_DELAY,
  input wire PULLDOWN_DISABLE_WR,
  input wire PULLDOWN_DISABLE_VAL,
  output reg [NRES-1:0] RES_ENABLE,
  output reg [NRES-1:0] RES_PENDING,
  output reg [NRES-1:0] RES_REQUIRED,
  output reg REG_ENABLE,
  output reg WLAN_RESET,
  output reg PULLDOWN_EN,
  output reg OUT_ENABLE
);
  // resource state one-hot codes
  localparam ST_OFF = 4'b0001;
  localparam ST_ON = 4'b0010;
  localparam ST_TON = 4'b0100;
  localparam ST_TOFF = 4'b1000;

  // pin inputs pass three flops; changes count when stages 2 and 3 agree
  reg [2:0] lpo_s_q;
  reg [2:0] wl_s_q;
  reg [2:0] bt_s_q;
  reg [2:0] sd_s_q;
  reg wl_q;
  reg bt_q;
  reg sd_q;
  reg lpo_q;
  reg tick_q;
  wire lpo_rise;
  wire sd_run;

  always @(posedge MCLK) begin
    if (RST) begin
      lpo_s_q <= 3'h0;
      wl_s_q <= 3'h0;
      bt_s_q <= 3'h0;
      sd_s_q <= 3'h0;
      wl_q <= 1'b0;
      bt_q <= 1'b0;
      sd_q <= 1'b0;
      lpo_q <= 1'b0;
    end else begin
      lpo_s_q <= {lpo_s_q[1:0], LOW_POWER_OSC_CLOCK};
      wl_s_q <= {wl_s_q[1:0], WLAN_POWER_CTRL_IN};
      bt_s_q <= {bt_s_q[1:0], BT_POWER_CTRL_IN};
      sd_s_q <= {sd_s_q[1:0], SHUTDOWN};
      if (wl_s_q[1] == wl_s_q[2])
        wl_q <= wl_s_q[2];
      if (bt_s_q[1] == bt_s_q[2])
        bt_q <= bt_s_q[2];
      if (sd_s_q[1] == sd_s_q[2])
        sd_q <= sd_s_q[2];
      if (lpo_s_q[1] == lpo_s_q[2])
        lpo_q <= lpo_s_q[2];
    end
  end

  // low-power clock sampled as a tick so it can keep running in doze
  // an edge counts only once stages 2 and 3 agree on the new level
  assign lpo_rise = (lpo_s_q[1] == lpo_s_q[2]) & lpo_s_q[2] & ~lpo_q;
  always @(posedge MCLK) begin
    if (RST)
      tick_q <= 1'b0;
    else
      tick_q <= lpo_rise;
  end

  // shutdown acts as a reset for the resource state machines and RES_ENABLE/RES_PENDING
  assign sd_run = ~(RST | sd_q);

  // clock requests mapped to resources
  reg [NRES-1:0] clk_res;
  integer c;
  always @* begin
    clk_res = {NRES{1'b0}};
    for (c = 0; c < NCLK; c = c + 1)
      if (CLK_REQ[c])
        clk_res = clk_res | CLK_MAP[c*NRES +: NRES];
  end

  // raw request and its closure over dependencies
  wire [NRES-1:0] req_raw = clk_res | MIN_RESOURCE_MASK | TIMER_REQ;
  reg [NRES-1:0] req_all;
  integer p;
  integer q;
  always @* begin
    req_all = req_raw;
    // NRES passes reach any dependency chain depth
    for (p = 0; p < NRES; p = p + 1)
      for (q = 0; q < NRES; q = q + 1)
        if (req_all[q])
          req_all = req_all | DEP_TABLE[q*NRES +: NRES];
  end

  reg [NRES-1:0] powered;
  wire [NRES-1:0] settled_on;
  genvar g;
  generate
    for (g = 0; g < NRES; g = g + 1) begin : g_res
      reg [3:0] st_q;
      reg [3:0] st_d;
      reg [TW-1:0] tmr_q;
      reg [TW-1:0] tmr_d;
      wire [NRES-1:0] deps = DEP_TABLE[g*NRES +: NRES];
      wire [TW-1:0] on_dly = ON_DELAY[g*TW +: TW];
      wire [TW-1:0] off_dly = OFF_DELAY[g*TW +: TW];
      reg dependent_up;
      integer k;

      // a dependent counts as up unless it is fully off
      always @* begin
        dependent_up = 1'b0;
        for (k = 0; k < NRES; k = k + 1)
          if (DEP_TABLE[k*NRES + g] && powered[k])
            dependent_up = 1'b1;
      end

      always @* begin
        st_d = st_q;
        tmr_d = tmr_q;
        case (st_q)
          ST_OFF: begin
            if (req_all[g] && ((deps & ~settled_on) == {NRES{1'b0}})) begin
              if (on_dly == {TW{1'b0}})
                st_d = ST_ON;
              else begin
                st_d = ST_TON;
                tmr_d = on_dly;
              end
            end
          end
          ST_ON: begin
            if (!req_all[g] && !dependent_up) begin
              if (off_dly == {TW{1'b0}})
                st_d = ST_OFF;
              else begin
                st_d = ST_TOFF;
                tmr_d = off_dly;
              end
            end
          end
          ST_TON, ST_TOFF: begin
            // requests ignored while moving
            tmr_d = tmr_q - {{(TW-1){1'b0}}, 1'b1};
            if (tmr_d == {TW{1'b0}})
              st_d = (st_q == ST_TON) ? ST_ON : ST_OFF;
          end
          default: begin
            st_d = ST_OFF;
            tmr_d = `PRS_RESET_TIMER;
          end
        endcase
      end

      // state only advances on a low-power tick
      always @(posedge MCLK) begin
        if (!sd_run) begin
          st_q <= ST_OFF;
          tmr_q <= `PRS_RESET_TIMER;
        end else if (tick_q) begin
          st_q <= st_d;
          tmr_q <= tmr_d;
        end
      end

      assign settled_on[g] = st_q[1];
      always @* powered[g] = ~st_q[0];

      always @(posedge MCLK) begin
        if (!sd_run) begin
          RES_ENABLE[g] <= 1'b0;
          RES_PENDING[g] <= 1'b0;
        end else begin
          RES_ENABLE[g] <= st_q[1] | st_q[3];
          RES_PENDING[g] <= st_q[2] | st_q[3];
        end
      end
    end
  endgenerate

  // power control gating and pad behaviour
  always @(posedge MCLK) begin
    if (RST) begin
      RES_REQUIRED <= `PRS_RESET_MASK;
      REG_ENABLE <= 1'b0;
      WLAN_RESET <= 1'b1;
      PULLDOWN_EN <= 1'b1;
      OUT_ENABLE <= 1'b0;
    end else begin
      RES_REQUIRED <= sd_q ? `PRS_RESET_MASK : req_all;
      REG_ENABLE <= wl_q | bt_q;
      WLAN_RESET <= ~wl_q;
      if (PULLDOWN_DISABLE_WR)
        PULLDOWN_EN <= ~PULLDOWN_DISABLE_VAL;
      // pads float in shutdown to avoid loading the host's lines
      OUT_ENABLE <= ~sd_q;
    end
  end
endmodule // prs_sequencer

/* core/prs_defines.vh */
// constants for the power resource sequencer
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH
`define PRS_NRES 8
`define PRS_NCLK 4
`define PRS_TW 8
`define PRS_RESET_TIMER 8'h00
`define PRS_RESET_MASK 8'h00
`define PRS_SYNC_STAGES 3
`endif

/* testbench/prs_host.sv */
// host model: power control pins and low-power clock
`timescale 1ns/1ns
module prs_host #(
  parameter HALF = 400
) (
  output logic wl,
  output logic bt,
  output logic low_power_osc_clock
);
  initial {wl, bt, low_power_osc_clock} = 3'h0;
  // sped up far past the real rate to keep runs short; free-running
  always #HALF low_power_osc_clock = ~low_power_osc_clock;
  task set(input logic w, input logic b);
    {wl, bt} = {w, b};
  endtask
endmodule // prs_host

/* testbench/prs_sequencer_sva.sv */
// port assertions for the sequencer
`timescale 1ns/1ns
module prs_sequencer_sva (
  input wire MCLK,
  input wire RST,
  input wire WLAN_POWER_CTRL_IN,
  input wire BT_POWER_CTRL_IN,
  input wire SHUTDOWN,
  input wire PULLDOWN_DISABLE_WR,
  input wire PULLDOWN_DISABLE_VAL,
  input wire [7:0] RES_ENABLE,
  input wire [7:0] RES_PENDING,
  input wire REG_ENABLE,
  input wire WLAN_RESET,
  input wire PULLDOWN_EN,
  input wire OUT_ENABLE
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  reg_on_a: assert property ($rose(WLAN_POWER_CTRL_IN) |-> ##[3:6] REG_ENABLE)
    else $error("reg on");
  reg_off_a: assert property ($fell(WLAN_POWER_CTRL_IN | BT_POWER_CTRL_IN) |-> ##[3:6] !REG_ENABLE)
    else $error("reg off");
  wl_run_a: assert property ($rose(WLAN_POWER_CTRL_IN) |-> ##[3:6] !WLAN_RESET)
    else $error("wl run");
  wl_hold_a: assert property ($fell(WLAN_POWER_CTRL_IN) |-> ##[3:6] WLAN_RESET)
    else $error("wl hold");
  pd_write_a: assert property (PULLDOWN_DISABLE_WR |=> PULLDOWN_EN != $past(PULLDOWN_DISABLE_VAL))
    else $error("pd write");
  pd_keep_a: assert property (!PULLDOWN_DISABLE_WR |=> $stable(PULLDOWN_EN))
    else $error("pd keep");
  shut_off_a: assert property (SHUTDOWN [*7] |-> RES_ENABLE == 8'h00 && !OUT_ENABLE)
    else $error("shutdown");
  expiry_a: assert property ($fell(RES_PENDING[0]) && OUT_ENABLE |-> $changed(RES_ENABLE[0]))
    else $error("expiry");
endmodule // prs_sequencer_sva
bind prs_sequencer prs_sequencer_sva i_sva (.*);

/* testbench/prs_sequencer_bench.sv */
// sequencer bench with reference model
`timescale 1ns/1ns
module prs_sequencer_bench;
  logic c = 0, rst = 1, sd = 0, pw = 0, pv = 0;
  logic wl, bt, low_power_osc_clock, rge, wrs, pde, oe;
  logic [3:0] cr = 0;
  logic [31:0] cm = 0;
  logic [7:0] mn = 0, tr = 0, en, pd, rq, me = 0, mp = 0;
  logic [63:0] od = 0, fd = 0, dt = 0;
  integer seed = 32'he5ea, miscompares = 0, num_checks = 0, n = 0, i, j, k;
  integer t[8];
  always #4 c = ~c;
  prs_host h (.wl(wl), .bt(bt), .low_power_osc_clock(low_power_osc_clock));
  prs_sequencer i_prs_sequencer (.MCLK(c), .RST(rst), .LOW_POWER_OSC_CLOCK(low_power_osc_clock),
    .WLAN_POWER_CTRL_IN(wl), .BT_POWER_CTRL_IN(bt), .SHUTDOWN(sd), .CLK_REQ(cr),
    .CLK_MAP(cm), .MIN_RESOURCE_MASK(mn), .TIMER_REQ(tr), .DEP_TABLE(dt),
    .ON_DELAY(od), .OFF_DELAY(fd), .PULLDOWN_DISABLE_WR(pw), .PULLDOWN_DISABLE_VAL(pv),
    .RES_ENABLE(en), .RES_PENDING(pd), .RES_REQUIRED(rq), .REG_ENABLE(rge),
    .WLAN_RESET(wrs), .PULLDOWN_EN(pde), .OUT_ENABLE(oe));
  task cmp(input logic [23:0] got, input logic [23:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one sequencer tick; compare mid-period, well clear of the synchronisers
  task step;
    logic [7:0] r, s, w;
    logic u;
    r = mn | tr;
    for (i = 0; i < 4; i++) if (cr[i]) r = r | cm[i*8 +: 8];
    for (j = 0; j < 8; j++) for (i = 0; i < 8; i++) if (r[i]) r = r | dt[i*8 +: 8];
    @(posedge low_power_osc_clock);
    repeat (50) @(negedge c);
    // decisions use the state from before this tick
    s = me & ~mp;
    w = me | mp;
    for (i = 0; i < 8; i++) begin
      u = 0;
      for (j = 0; j < 8; j++) if (dt[j*8 + i] && w[j]) u = 1;
      k = me[i] ? fd[i*8 +: 8] : od[i*8 +: 8];
      if (mp[i]) begin
        t[i] = t[i] - 1;
        if (t[i] == 0) {mp[i], me[i]} = {1'b0, ~me[i]};
      end else if (me[i] ? !r[i] && !u : r[i] && (dt[i*8 +: 8] & ~s) == 0) begin
        t[i] = k;
        if (k == 0) me[i] = ~me[i];
        else mp[i] = 1'b1;
      end
    end
    cmp({rq, en, pd}, {r, me, mp});
  endtask
  always @(posedge c) begin
    n = n + 1;
    if (n == 20000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(negedge c);
    rst = 0;
    cmp(pde, 1);
    repeat (30) begin
      {mn, tr, cr} = $random(seed);
      cm = $random(seed);
      od = {$random(seed), $random(seed)} & 64'h0303030303030303;
      fd = {$random(seed), $random(seed)} & 64'h0303030303030303;
      // each resource depends only on lower ones, so no cycles
      dt = {$random(seed), $random(seed)};
      for (i = 0; i < 8; i++) dt[i*8 +: 8] = dt[i*8 +: 8] & ((8'h01 << i) - 8'h01);
      step;
    end
    $display("sequencing done");
    for (j = 1; j < 5; j++) begin
      h.set(j[1], j[0]);
      repeat (8) @(negedge c);
      cmp(rge, j != 4);
      cmp(wrs, !j[1]);
    end
    for (j = 0; j < 2; j++) begin
      {pw, pv} = {1'b1, ~j[0]};
      @(negedge c);
      pw = 0;
      cmp(pde, j);
    end
    $display("pins done");
    sd = 1;
    repeat (8) @(negedge c);
    cmp({oe, rq, en}, 0);
    sd = 0;
    {me, mp} = 0;
    repeat (3) step;
    cmp(oe, 1);
    $display("shutdown done");
    wrap_up;
  end
endmodule // prs_sequencer_bench
